/* File: rtl/ppmc_top.sv */
`timescale 1ns/10ps
`default_nettype none
module ppmc_top
  import ppmc_pkg::*;
#(
  parameter int TICK_CYC_P    = TICK_CYC,
  parameter int RECOV_TICKS_P = RECOV_TICKS
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              lk_clk,
  input  wire logic              lk_wr_stb,
  input  wire logic              lk_rd_stb,
  input  wire logic [ADDR_W-1:0] lk_addr,
  input  wire logic [DATA_W-1:0] lk_wdata,
  output logic                   lk_ready,
  output logic      [DATA_W-1:0] lk_status,
  input  wire logic [2:0]        ov_thr_code,
  input  wire logic [2:0]        ov_dly_code,
  input  wire logic [1:0]        ov_hys_code,
  input  wire logic [3:0]        uv_thr_code,
  input  wire logic [3:0]        uv_dly_code,
  input  wire logic [2:0]        uv_hys_code,
  input  wire logic [3:0]        ocd_thr_code,
  input  wire logic [7:0]        overcurrent_delay_reg,
  input  wire logic [3:0]        scd_thr_code,
  input  wire logic [3:0]        scd_dly_code,
  input  wire logic              ov_cmp,
  input  wire logic              ov_rec_cmp,
  input  wire logic              uv_cmp,
  input  wire logic              uv_rec_cmp,
  input  wire logic              ocd_cmp,
  input  wire logic              scd_cmp,
  input  wire logic              charger_cmp,
  input  wire logic [NCELL-1:0]  cell_high,
  output logic                   host_mode,
  output logic                   charge_fet_drive,
  output logic                   discharge_fet_drive,
  output logic                   alert_out_n,
  output logic      [MV_W-1:0]   ov_level_mv,
  output logic      [MV_W-1:0]   ov_recov_mv,
  output logic      [MV_W-1:0]   uv_level_mv,
  output logic      [MV_W-1:0]   uv_recov_mv,
  output logic      [MV_W-1:0]   ocd_level_mv,
  output logic      [MV_W-1:0]   scd_level_mv,
  output logic                   cell_amp_enable,
  output logic                   current_amp_enable,
  output logic                   current_amp_offset_cal,
  output ppmc_mon_e              mon_src,
  output logic      [MV_W-1:0]   cell_ref_mv,
  output logic      [5:0]        current_gain,
  output logic      [NCELL-1:0]  cell_bal_en
);
  ppmc_cmd_if cmd ();

  logic [NSYNC-1:0]  sync_m, sync_s, cmp_raw;
  logic              ov_s, ov_rec_s, uv_s, uv_rec_s, ocd_s, scd_s, chgr_s;
  logic [NCELL-1:0]  high_s;
  logic [15:0]       tick_cnt_q;
  logic              tick_q;
  logic [DLY_W-1:0]  lim_q [NFAULT];
  logic [NFAULT-1:0] det, trip, clr, flt_q;
  logic [2:0]        state_q;
  logic [7:0]        func_q;
  logic [NCELL-1:0]  bal_q;
  logic              lclr_prev_q, lclr_fall;
  logic              alert_pend_q;
  logic              chg_off, dsg_off, va;
  logic [MV_W-1:0]   ovh_mv, uvh_mv;
  logic              oc_done_q;
  logic [DLY_W-1:0]  rcnt_q;
  ppmc_oc_state_e    oc_state_q;

  ppmc_link_cdc u_link (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .lk_clk    (lk_clk),
    .lk_wr_stb (lk_wr_stb),
    .lk_rd_stb (lk_rd_stb),
    .lk_addr   (lk_addr),
    .lk_wdata  (lk_wdata),
    .lk_ready  (lk_ready),
    .status_in ({3'h0, state_q[SC_HOST], flt_q}),
    .lk_status (lk_status),
    .cmd       (cmd)
  );

  ////////////////////////////////////////////////////////////////////////
  // comparator synchronisers
  assign cmp_raw = {cell_high, charger_cmp, scd_cmp, ocd_cmp, uv_rec_cmp,
                    uv_cmp, ov_rec_cmp, ov_cmp};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge mclk) begin
        sync_m[g] <= cmp_raw[g];
        sync_s[g] <= sync_m[g];
      end
    end
  endgenerate

  assign {high_s, chgr_s, scd_s, ocd_s, uv_rec_s, uv_s, ov_rec_s, ov_s} =
    sync_s;
  assign det = {scd_s, ocd_s, uv_s, ov_s};

  ////////////////////////////////////////////////////////////////////////
  // timebase
  always_ff @(posedge mclk) begin
    if (!rst_n || tick_cnt_q == 16'(TICK_CYC_P - 1)) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    tick_q <= rst_n && (tick_cnt_q == 16'(TICK_CYC_P - 1));
  end

  ////////////////////////////////////////////////////////////////////////
  // delay limits in ticks
  always_ff @(posedge mclk) begin
    lim_q[F_OV] <= DLY_W'((OV_BASE_MS + int'(ov_dly_code) * OV_STEP_MS)
                          * TICKS_PER_MS);
    if (uv_dly_code[3]) begin
      lim_q[F_UV] <= DLY_W'((int'(uv_dly_code) - UV_LONG_OFS) * UV_LONG_MS
                            * TICKS_PER_MS);
    end else begin
      lim_q[F_UV] <= DLY_W'(UV_FINE_US[uv_dly_code[2:0]] / TICK_US);
    end
    if (int'(overcurrent_delay_reg[4:0]) < OCD_FINE_N) begin
      lim_q[F_OCD] <= DLY_W'((int'(overcurrent_delay_reg[4:0]) + 1)
                             * OCD_FINE_MS * TICKS_PER_MS);
    end else begin
      lim_q[F_OCD] <= DLY_W'((int'(overcurrent_delay_reg[4:0])
                              - OCD_FINE_N + 1)
                             * OCD_COARSE_MS * TICKS_PER_MS);
    end
    lim_q[F_SCD] <= DLY_W'(int'(scd_dly_code) * SCD_STEP_US
                           / TICK_US);
  end

  generate
    for (g = 0; g < NFAULT; g++) begin : g_tmr
      ppmc_dly_timer #(.W(DLY_W)) u_tmr (
        .clk   (mclk),
        .rst_n (rst_n),
        .tick  (tick_q),
        .cond  (det[g]),
        .limit (lim_q[g]),
        .trip  (trip[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // threshold levels for the analogue comparators
  assign ovh_mv = MV_W'(int'(ov_hys_code) * OVH_STEP_MV);
  assign uvh_mv = (int'(uv_hys_code) * UVH_STEP_MV + UVH_MIN_MV > UVH_MAX_MV)
                  ? MV_W'(UVH_MAX_MV)
                  : MV_W'(int'(uv_hys_code) * UVH_STEP_MV
                          + UVH_MIN_MV);

  always_ff @(posedge mclk) begin
    ov_level_mv  <= MV_W'(OV_MIN_MV + int'(ov_thr_code) * OV_STEP_MV);
    uv_level_mv  <= MV_W'(UV_MIN_MV + int'(uv_thr_code) * UV_STEP_MV);
    ocd_level_mv <= MV_W'(OCD_MIN_MV
                          + int'(ocd_thr_code) * CUR_STEP_MV);
    scd_level_mv <= MV_W'(SCD_MIN_MV
                          + int'(scd_thr_code) * CUR_STEP_MV);
    // host recovery ignores overvoltage hysteresis
    ov_recov_mv  <= state_q[SC_HOST] ? ov_level_mv
                                     : ov_level_mv - ovh_mv;
    uv_recov_mv  <= uv_level_mv + uvh_mv;
  end

  ////////////////////////////////////////////////////////////////////////
  // host registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= 3'h0;
    end else if (cmd.wr_stb && cmd.addr == ADDR_STATE_CTL) begin
      if (state_q[SC_HOST]) begin
        state_q <= cmd.data[2:0];
      end else begin
        state_q[SC_HOST] <= cmd.data[SC_HOST];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      func_q <= 8'h00;
    end else begin
      if (cmd.wr_stb && cmd.addr == ADDR_FUNC_CTL && state_q[SC_HOST]) begin
        func_q <= cmd.data;
      end
      // a trip drops the host's FET enable so it must be set again
      if (trip[F_OV] || trip[F_OCD] || trip[F_SCD]) begin
        func_q[FC_CHG] <= 1'b0;
      end
      if (trip[F_UV] || trip[F_OCD] || trip[F_SCD]) begin
        func_q[FC_DSG] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bal_q <= '0;
    end else if (cmd.wr_stb && state_q[SC_HOST]) begin
      if (cmd.addr == ADDR_BAL_LO) begin
        bal_q[7:0] <= cmd.data;
      end else if (cmd.addr == ADDR_BAL_HI) begin
        bal_q[NCELL-1:8] <= cmd.data[NCELL-9:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lclr_prev_q <= 1'b0;
    end else begin
      lclr_prev_q <= func_q[FC_LATCH_CLR];
    end
  end

  assign lclr_fall = lclr_prev_q && !func_q[FC_LATCH_CLR];

  ////////////////////////////////////////////////////////////////////////
  // stand-alone overcurrent recovery wait
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      oc_state_q <= PPMC_OC_IDLE;
      rcnt_q     <= '0;
      oc_done_q  <= 1'b0;
    end else begin
      oc_done_q <= 1'b0;
      case (oc_state_q)
        PPMC_OC_IDLE: begin
          rcnt_q <= '0;
          if (!state_q[SC_HOST] && (flt_q[F_OCD] || flt_q[F_SCD])) begin
            oc_state_q <= PPMC_OC_WAIT;
          end
        end
        PPMC_OC_WAIT: begin
          if (state_q[SC_HOST]) begin
            oc_state_q <= PPMC_OC_IDLE;
          end else if (rcnt_q >= DLY_W'(RECOV_TICKS_P)) begin
            oc_done_q  <= 1'b1;
            oc_state_q <= PPMC_OC_IDLE;
          end else if (tick_q) begin
            rcnt_q <= rcnt_q + 1'b1;
          end
        end
        default: oc_state_q <= PPMC_OC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fault latches
  always_comb begin
    if (state_q[SC_HOST]) begin
      clr = {NFAULT{lclr_fall}} & ~det;
    end else begin
      clr[F_OV]  = ov_rec_s;
      clr[F_UV]  = uv_rec_s || (chgr_s && !uv_s);
      clr[F_OCD] = oc_done_q;
      clr[F_SCD] = oc_done_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flt_q <= '0;
    end else begin
      flt_q <= (flt_q & ~clr) | trip;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // FET drive and alert
  assign chg_off = flt_q[F_OV] || flt_q[F_OCD] || flt_q[F_SCD];
  assign dsg_off = flt_q[F_UV] || flt_q[F_OCD] || flt_q[F_SCD];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      charge_fet_drive    <= 1'b0;
      discharge_fet_drive <= 1'b0;
    end else if (state_q[SC_HOST]) begin
      charge_fet_drive    <= func_q[FC_CHG] && !chg_off;
      discharge_fet_drive <= func_q[FC_DSG] && !dsg_off;
    end else begin
      charge_fet_drive    <= !chg_off;
      discharge_fet_drive <= !dsg_off;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      alert_pend_q <= 1'b0;
    end else if (|trip) begin
      alert_pend_q <= 1'b1;
    end else if (flt_q == '0
                 && (!state_q[SC_HOST]
                     || (cmd.rd_stb && cmd.addr == ADDR_STATUS))) begin
      alert_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      alert_out_n <= 1'b1;
    end else begin
      alert_out_n <= !alert_pend_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // analogue monitor steering and balancing
  assign va = state_q[SC_HOST] && func_q[FC_CELL_AMP];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      host_mode              <= 1'b0;
      cell_amp_enable        <= 1'b0;
      current_amp_enable     <= 1'b0;
      current_amp_offset_cal <= 1'b0;
      mon_src                <= PPMC_MON_CELL;
      cell_ref_mv            <= MV_W'(CELL_REF_LO_MV);
      current_gain           <= 6'(CUR_GAIN_LO);
      cell_bal_en            <= '0;
    end else begin
      host_mode              <= state_q[SC_HOST];
      cell_amp_enable        <= va;
      current_amp_enable     <= state_q[SC_HOST] && func_q[FC_CUR_AMP];
      current_amp_offset_cal <= state_q[SC_HOST] && func_q[FC_CUR_CAL];
      if (va && func_q[FC_PACK]) begin
        mon_src <= PPMC_MON_PACK;
      end else if (va && func_q[FC_BAT]) begin
        mon_src <= PPMC_MON_BAT;
      end else begin
        mon_src <= PPMC_MON_CELL;
      end
      cell_ref_mv  <= state_q[SC_CELL_GAIN] ? MV_W'(CELL_REF_HI_MV)
                                            : MV_W'(CELL_REF_LO_MV);
      current_gain <= state_q[SC_CUR_GAIN] ? 6'(CUR_GAIN_HI)
                                           : 6'(CUR_GAIN_LO);
      if (state_q[SC_HOST]) begin
        cell_bal_en <= bal_q;
      end else if (overcurrent_delay_reg[OCDR_AUTO_BAL] && flt_q == '0) begin
        cell_bal_en <= high_s;
      end else begin
        cell_bal_en <= '0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: pkg/ppmc_pkg.sv */
package ppmc_pkg;
  localparam int CLK_MHZ      = 100;
  localparam int TICK_US      = 10;
  localparam int TICK_CYC     = CLK_MHZ * TICK_US;
  localparam int TICKS_PER_MS = 1000 / TICK_US;
  localparam int DLY_W        = 21;
  localparam int MV_W         = 13;
  localparam int NCELL        = 10;
  localparam int NSYNC        = 17;
  localparam int ADDR_W       = 4;
  localparam int DATA_W       = 8;
  // delay codes
  localparam int OV_BASE_MS   = 500;
  localparam int OV_STEP_MS   = 250;
  localparam int UV_FINE_US [8] = '{0, 1250, 2500, 5000, 10000, 15000,
                                    20000, 30000};
  localparam int UV_LONG_OFS  = 7;
  localparam int UV_LONG_MS   = 1000;
  localparam int OCD_FINE_MS  = 20;
  localparam int OCD_COARSE_MS = 100;
  localparam int OCD_FINE_N   = 16;
  localparam int SCD_STEP_US  = 60;
  localparam int RECOV_MS     = 12800;
  localparam int RECOV_TICKS  = RECOV_MS * TICKS_PER_MS;
  // threshold codes
  localparam int OV_MIN_MV    = 4150;
  localparam int OV_STEP_MV   = 50;
  localparam int UV_MIN_MV    = 1400;
  localparam int UV_STEP_MV   = 100;
  localparam int OCD_MIN_MV   = 10;
  localparam int SCD_MIN_MV   = 60;
  localparam int CUR_STEP_MV  = 5;
  localparam int OVH_STEP_MV  = 100;
  localparam int UVH_MIN_MV   = 200;
  localparam int UVH_STEP_MV  = 200;
  localparam int UVH_MAX_MV   = 1200;
  // monitor
  localparam int CELL_REF_LO_MV = 975;
  localparam int CELL_REF_HI_MV = 1200;
  localparam int CUR_GAIN_LO  = 10;
  localparam int CUR_GAIN_HI  = 50;
  // register addresses and fields
  localparam logic [3:0] ADDR_STATE_CTL = 4'h0;
  localparam logic [3:0] ADDR_FUNC_CTL  = 4'h1;
  localparam logic [3:0] ADDR_BAL_LO    = 4'h2;
  localparam logic [3:0] ADDR_BAL_HI    = 4'h3;
  localparam logic [3:0] ADDR_STATUS    = 4'h4;
  localparam int SC_HOST = 0;
  localparam int SC_CELL_GAIN = 1;
  localparam int SC_CUR_GAIN = 2;
  localparam int FC_CELL_AMP = 0;
  localparam int FC_CUR_AMP = 1;
  localparam int FC_CUR_CAL = 2;
  localparam int FC_PACK = 3;
  localparam int FC_BAT = 4;
  localparam int FC_CHG = 5;
  localparam int FC_DSG = 6;
  localparam int FC_LATCH_CLR = 7;
  localparam int OCDR_AUTO_BAL = 7;
  localparam int F_OV = 0;
  localparam int F_UV = 1;
  localparam int F_OCD = 2;
  localparam int F_SCD = 3;
  localparam int NFAULT = 4;
  localparam int ST_HOST = 4;
  typedef enum logic [1:0] {PPMC_MON_CELL, PPMC_MON_PACK,
                            PPMC_MON_BAT} ppmc_mon_e;
  typedef enum logic {PPMC_OC_IDLE, PPMC_OC_WAIT} ppmc_oc_state_e;
endpackage

/* File: pkg/ppmc_cmd_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface ppmc_cmd_if;
  import ppmc_pkg::*;
  logic              wr_stb;
  logic              rd_stb;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data;
  modport src (output wr_stb, output rd_stb, output addr, output data);
  modport dst (input wr_stb, input rd_stb, input addr, input data);
endinterface
`default_nettype wire

/* File: rtl/ppmc_dly_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module ppmc_dly_timer #(
  parameter int W = 21
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         tick,
  input  wire logic         cond,
  input  wire logic [W-1:0] limit,
  output logic              trip
);
  logic [W-1:0] cnt_q;
  logic         trip_q;

  // counts timebase ticks while the condition holds
  always_ff @(posedge clk) begin
    if (!rst_n || !cond) begin
      cnt_q <= '0;
    end else if (tick && cnt_q < limit) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trip_q <= 1'b0;
    end else begin
      trip_q <= cond && (cnt_q >= limit);
    end
  end

  assign trip = trip_q;
endmodule
`default_nettype wire

/* File: rtl/ppmc_link_cdc.sv */
`timescale 1ns/10ps
`default_nettype none
module ppmc_link_cdc
  import ppmc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              lk_clk,
  input  wire logic              lk_wr_stb,
  input  wire logic              lk_rd_stb,
  input  wire logic [ADDR_W-1:0] lk_addr,
  input  wire logic [DATA_W-1:0] lk_wdata,
  output logic                   lk_ready,
  input  wire logic [DATA_W-1:0] status_in,
  output logic      [DATA_W-1:0] lk_status,
  ppmc_cmd_if.src                cmd
);
  logic              lrst_m, lrst_n;
  logic              req_q, hold_rd_q, ack_m, ack_s;
  logic [ADDR_W-1:0] hold_addr_q;
  logic [DATA_W-1:0] hold_data_q, st_m, st_s;
  logic              req_m, req_s, seen_q;
  logic              wr_q, rd_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] data_q;

  ////////////////////////////////////////////////////////////////////////
  // link side
  always_ff @(posedge lk_clk) begin
    lrst_m <= rst_n;
    lrst_n <= lrst_m;
  end

  always_ff @(posedge lk_clk) begin
    ack_m <= seen_q;
    ack_s <= ack_m;
    st_m  <= status_in;
    st_s  <= st_m;
  end

  assign lk_ready  = (ack_s == req_q);
  assign lk_status = st_s;

  always_ff @(posedge lk_clk) begin
    if (!lrst_n) begin
      req_q       <= 1'b0;
      hold_rd_q   <= 1'b0;
      hold_addr_q <= '0;
      hold_data_q <= '0;
    end else if (lk_ready && (lk_wr_stb || lk_rd_stb)) begin
      req_q       <= ~req_q;
      hold_rd_q   <= !lk_wr_stb;
      hold_addr_q <= lk_addr;
      hold_data_q <= lk_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core side
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      req_m <= 1'b0;
      req_s <= 1'b0;
    end else begin
      req_m <= req_q;
      req_s <= req_m;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      seen_q <= 1'b0;
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= '0;
      data_q <= '0;
    end else begin
      wr_q <= (req_s != seen_q) && !hold_rd_q;
      rd_q <= (req_s != seen_q) && hold_rd_q;
      if (req_s != seen_q) begin
        seen_q <= req_s;
        addr_q <= hold_addr_q;
        data_q <= hold_data_q;
      end
    end
  end

  assign cmd.wr_stb = wr_q;
  assign cmd.rd_stb = rd_q;
  assign cmd.addr   = addr_q;
  assign cmd.data   = data_q;
endmodule
`default_nettype wire

/* File: tb/ppmc_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module ppmc_chk
  import ppmc_pkg::*;
(
  input wire logic             mclk,
  input wire logic             rst_n,
  input wire logic [2:0]       ov_thr_code,
  input wire logic [1:0]       ov_hys_code,
  input wire logic [3:0]       uv_thr_code,
  input wire logic [2:0]       uv_hys_code,
  input wire logic [3:0]       ocd_thr_code,
  input wire logic [7:0]       overcurrent_delay_reg,
  input wire logic             host_mode,
  input wire logic             charge_fet_drive,
  input wire logic             alert_out_n,
  input wire logic [MV_W-1:0]  ov_level_mv,
  input wire logic [MV_W-1:0]  ov_recov_mv,
  input wire logic [MV_W-1:0]  uv_level_mv,
  input wire logic [MV_W-1:0]  uv_recov_mv,
  input wire logic [MV_W-1:0]  ocd_level_mv,
  input wire logic             cell_amp_enable,
  input wire logic             current_amp_enable,
  input wire logic [NCELL-1:0] cell_bal_en
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_sa_trip;
    !host_mode && $fell(charge_fet_drive);
  endsequence
  property p_trip_alert;
    s_sa_trip |=> !alert_out_n;
  endproperty
  a_ov_level: assert property (
    ov_level_mv == OV_MIN_MV + OV_STEP_MV * $past(ov_thr_code))
    else $error("ov level wrong");
  a_uv_level: assert property (
    uv_level_mv == UV_MIN_MV + UV_STEP_MV * $past(uv_thr_code))
    else $error("uv level wrong");
  a_ocd_level: assert property (
    ocd_level_mv == OCD_MIN_MV + CUR_STEP_MV * $past(ocd_thr_code))
    else $error("ocd level wrong");
  a_ov_recov: assert property (
    ov_recov_mv == OV_MIN_MV + OV_STEP_MV * $past(ov_thr_code, 2)
    - (host_mode ? 0 : OVH_STEP_MV * $past(ov_hys_code)))
    else $error("ov recov wrong");
  a_uv_recov: assert property (
    uv_recov_mv == UV_MIN_MV + UV_STEP_MV * $past(uv_thr_code, 2)
    + ($past(uv_hys_code) > 5 ? UVH_MAX_MV
    : UVH_MIN_MV + UVH_STEP_MV * $past(uv_hys_code)))
    else $error("uv recov wrong");
  a_bal_off: assert property (
    !host_mode && $past(!host_mode) && !$past(overcurrent_delay_reg[7])
    && !$past(overcurrent_delay_reg[7], 2) |-> cell_bal_en == '0)
    else $error("balance without enable");
  a_amps_off: assert property (
    !host_mode && $past(!host_mode) |-> !cell_amp_enable
    && !current_amp_enable) else $error("amp on in stand-alone");
  a_trip_alert: assert property (p_trip_alert)
    else $error("no alert on trip");
endmodule
bind ppmc_top ppmc_chk u_chk (.*);
`default_nettype wire

/* File: tb/ppmc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ppmc_host_model
  import ppmc_pkg::*;
(
  input  wire logic              lk_clk,
  input  wire logic              lk_ready,
  output logic                   lk_wr_stb,
  output logic                   lk_rd_stb,
  output logic      [ADDR_W-1:0] lk_addr,
  output logic      [DATA_W-1:0] lk_wdata
);
  initial begin
    {lk_wr_stb, lk_rd_stb, lk_addr, lk_wdata} = '0;
  end
  task automatic wait_rdy();
    for (int n = 0; n < 40 && lk_ready !== 1'b1; n++) begin
      @(posedge lk_clk);
      #1;
    end
  endtask
  // request held until the edge that takes it
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    @(posedge lk_clk);
    #1;
    wait_rdy();
    {lk_wr_stb, lk_rd_stb, lk_addr, lk_wdata} = {wr, !wr, a, d};
    @(posedge lk_clk);
    #1;
    {lk_wr_stb, lk_rd_stb, lk_addr, lk_wdata} = {2'h0, ~a, ~d};
    @(posedge lk_clk);
    #1;
    wait_rdy();
  endtask
  // latch clear pulse, then fet bits back on
  task automatic recover(input logic [DATA_W-1:0] fc);
    xfer(1'b1, ADDR_FUNC_CTL, fc | 8'h80);
    xfer(1'b1, ADDR_FUNC_CTL, fc);
    xfer(1'b1, ADDR_FUNC_CTL, fc | 8'h60);
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ppmc_pkg::*;
  logic        mclk, rst_n, lk_clk, lk_wr_stb, lk_rd_stb, lk_ready;
  logic        ov_cmp, ov_rec_cmp, uv_cmp, uv_rec_cmp, ocd_cmp, scd_cmp;
  logic        charger_cmp, host_mode, charge_fet_drive, alert_out_n;
  logic        discharge_fet_drive, cell_amp_enable, current_amp_enable;
  logic        current_amp_offset_cal;
  logic [1:0]  ov_hys_code;
  logic [2:0]  ov_thr_code, ov_dly_code, uv_hys_code;
  logic [3:0]  lk_addr, uv_thr_code, uv_dly_code, ocd_thr_code;
  logic [3:0]  scd_thr_code, scd_dly_code;
  logic [5:0]  current_gain;
  logic [7:0]  lk_wdata, lk_status, overcurrent_delay_reg;
  logic [9:0]  cell_high, cell_bal_en;
  logic [12:0] ov_level_mv, ov_recov_mv, uv_level_mv, uv_recov_mv;
  logic [12:0] ocd_level_mv, scd_level_mv, cell_ref_mv;
  ppmc_mon_e   mon_src;
  int          errors, checks, cyc, n;
  ppmc_top #(.TICK_CYC_P(2), .RECOV_TICKS_P(50)) u_dut (.*);
  ppmc_host_model u_host (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic w(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always #6 lk_clk = ~lk_clk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    {ov_cmp, uv_cmp, ocd_cmp, scd_cmp, charger_cmp, rst_n} = '0;
    {ov_rec_cmp, uv_rec_cmp, lk_clk} = '1;
    {ov_thr_code, ov_dly_code, ov_hys_code, uv_thr_code, uv_dly_code} = '0;
    {uv_hys_code, ocd_thr_code, scd_thr_code, scd_dly_code} = '0;
    {overcurrent_delay_reg, cell_high} = '0;
    w(4);
    rst_n = 1'b1;
    w(10);
    chk({charge_fet_drive, discharge_fet_drive}, 2'h3);
    chk({alert_out_n, host_mode}, 2'h2);
    chk(cell_ref_mv, 975);
    chk(current_gain, 10);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      {ov_thr_code, ov_hys_code, uv_hys_code} = {i[2:0], i[1:0], i[2:0]};
      {uv_thr_code, ocd_thr_code, scd_thr_code} = {3{i[3:0]}};
      w(3);
      chk(ov_level_mv, 4150 + 50 * i[2:0]);
      chk(uv_level_mv, 1400 + 100 * i);
      chk(ocd_level_mv, 10 + 5 * i);
      chk(scd_level_mv, 60 + 5 * i);
      chk(ov_recov_mv, 4150 + 50 * i[2:0] - 100 * i[1:0]);
      n = (i[2:0] > 5) ? 1200 : 200 + 200 * i[2:0];
      chk(uv_recov_mv, 1400 + 100 * i + n);
    end
    $display("test levels done");
    u_host.xfer(1'b1, ADDR_FUNC_CTL, 8'h1B);
    u_host.xfer(1'b1, ADDR_BAL_LO, 8'hFF);
    w(4);
    chk({cell_amp_enable, current_amp_enable}, 2'h0);
    chk(cell_bal_en, 10'h000);
    {overcurrent_delay_reg, cell_high} = {8'h80, 10'h205};
    w(6);
    chk(cell_bal_en, 10'h205);
    {overcurrent_delay_reg, cell_high} = '0;
    scd_dly_code = 4'h2;
    scd_cmp = 1'b1;
    w(16);
    scd_cmp = 1'b0;
    w(4);
    scd_cmp = 1'b1;
    w(16);
    chk(discharge_fet_drive, 1'b1);
    for (n = 16; n < 60 && discharge_fet_drive === 1'b1; n++)
      w(1);
    chk(n >= 24 && n <= 34, 1'b1);
    chk({charge_fet_drive, alert_out_n}, 2'h0);
    u_host.xfer(1'b0, ADDR_STATUS, 8'h00);
    chk(lk_status, 8'h08);
    scd_cmp = 1'b0;
    w(70);
    chk(discharge_fet_drive, 1'b0);
    w(50);
    chk({discharge_fet_drive, alert_out_n}, 2'h3);
    $display("test stand-alone done");
    u_host.xfer(1'b1, ADDR_STATE_CTL, 8'h07);
    w(4);
    chk(cell_ref_mv, 975);
    u_host.xfer(1'b1, ADDR_STATE_CTL, 8'h07);
    u_host.xfer(1'b1, ADDR_FUNC_CTL, 8'h6B);
    w(4);
    chk({host_mode, cell_amp_enable, mon_src}, {2'h3, PPMC_MON_PACK});
    chk(cell_ref_mv, 1200);
    chk(current_gain, 50);
    u_host.xfer(1'b1, ADDR_FUNC_CTL, 8'h77);
    w(4);
    chk(mon_src, PPMC_MON_BAT);
    chk(current_amp_offset_cal, 1'b1);
    scd_cmp = 1'b1;
    w(45);
    scd_cmp = 1'b0;
    w(150);
    chk({charge_fet_drive, discharge_fet_drive, alert_out_n}, 3'h0);
    u_host.recover(8'h13);
    w(4);
    chk({charge_fet_drive, discharge_fet_drive, alert_out_n}, 3'h6);
    u_host.xfer(1'b0, ADDR_STATUS, 8'h00);
    w(4);
    chk({alert_out_n, lk_status}, 9'h110);
    $display("test host done");
    rst_n = 1'b0;
    w(2);
    chk({host_mode, charge_fet_drive, alert_out_n}, 3'h1);
    w(2);
    rst_n = 1'b1;
    w(10);
    chk({host_mode, cell_amp_enable, discharge_fet_drive}, 3'h1);
    chk({cell_ref_mv, alert_out_n}, {13'd975, 1'b1});
    $display("test mid reset done");
    end_sim();
  end
endmodule
`default_nettype wire
